// ### common/rpm_pkg.sv
// Purpose: shared constants and types for the reset and power-mode controller
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package rpm_pkg;

	// clock rate and timing
	localparam int unsigned RPM_CLK_MHZ = 10;
	localparam int unsigned RPM_DLY_TIME_US = 2000;
	localparam int unsigned RPM_CNT_W = 16;
	localparam logic [15:0] RPM_DLY_CYCLES = 16'(RPM_DLY_TIME_US * RPM_CLK_MHZ);
	localparam int unsigned RPM_MC_CLKS = 6;
	localparam logic [3:0] RPM_RST_HOLD_CYCLES = 4'(2 * RPM_MC_CLKS);
	localparam logic [15:0] RPM_RESET_VECTOR = 16'h0000;

	// register offsets
	localparam logic [7:0] RPM_POWER_CONTROL_REGISTER_OFS = 8'h00;
	localparam logic [7:0] RPM_CLKCTL_OFS = 8'h04;
	localparam logic [7:0] RPM_WAKECFG_OFS = 8'h08;
	localparam logic [7:0] RPM_STATUS_OFS = 8'h0c;

	// power_control_register fields
	localparam int unsigned RPM_IDLE_BIT = 0;
	localparam int unsigned RPM_PD_BIT = 1;
	localparam int unsigned RPM_COLD_BIT = 4;
	// clock_control_register field
	localparam int unsigned RPM_WDS_BIT = 2;
	// wake configuration: enable in [1:0], level-sensitive select in [3:2]
	localparam int unsigned RPM_WEN_LSB = 0;
	localparam int unsigned RPM_WLVL_LSB = 2;
	// status fields
	localparam int unsigned RPM_ST_STATE_LSB = 0;
	localparam int unsigned RPM_ST_RST_BIT = 4;
	localparam int unsigned RPM_ST_OSC_BIT = 5;
	localparam int unsigned RPM_ST_WSRC_BIT = 6;

	// reset values
	localparam logic [3:0] RPM_WAKECFG_RST = 4'h0;

	typedef enum logic [2:0] {
		RPM_ST_RESET,
		RPM_ST_RUN,
		RPM_ST_IDLE,
		RPM_ST_PD,
		RPM_ST_WAKE_TIMED,
		RPM_ST_WAKE_EXT
	} rpm_state_t;

	typedef struct packed {
		logic cpu_rst;
		logic osc_en;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic port_hold;
		logic port_weak_pu;
		logic comp_en;
		logic flash_pwr_en;
		logic wake_irq;
		logic wake_src;
	} rpm_pwr_t;

endpackage : rpm_pkg

// ### hw/rpm_sync.sv
// Purpose: two-stage synchroniser for a group of asynchronous pins
// Assumes: one system clock, synchronous active-high reset
// Notes: first stage feeds only the second stage
module rpm_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi] <= i_d[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign o_q = sync_q;

endmodule : rpm_sync

// ### hw/rpm_top.sv
// Purpose: reset sequencing, idle and power-down control with APB registers
// Assumes: 10 MHz I_CLK, supply detectors and pins are asynchronous
// Notes: mode outputs are registered and aligned with the state register
//
// Functional notes
// [R1] external reset pin high for two machine cycles resets the device
// [R2] reset restores I/O registers, weak pull-ups on ports, start at 0000H
// [R3] internal reset combines power-on, brown-out and external pin sources
// [R4] after supply is good a 2 ms delay elapses before reset release
// [R5] power-on loss asserts internal reset at once, no delay counting
// [R6] oscillator enabled once power-on detect releases unless bypass fuse set
// [R7] cold power-on reset sets the cold-start flag
// [R8] clock input passes a divide-by-two stage
// [R9] idle request stops the CPU clock, CPU state kept
// [R10] port pins hold their levels during idle
// [R11] timers and serial port run in idle, comparator disabled
// [R12] idle ends on enabled interrupt or reset; interrupt serviced at once
// [R13] power-down stops oscillator and powers down program memory, RAM kept
// [R14] power-down exits on external reset, power-on reset or wake interrupt
// [R15] software waits 4 us before requesting power-down again
// [R16] only enabled level-sensitive wake pins leave power-down
// [R17] select zero: falling edge restarts oscillator, clock gated for 2 ms
// [R18] internally timed wake: pin held low until execution resumes
// [R19] select one: falling edge restarts oscillator, clock gated until rise
// [R20] externally timed wake: pin held low until oscillator is stable
// [R21] mode request bit cleared by hardware on leaving the mode
module rpm_top
	import rpm_pkg::*;
#(
	parameter logic [15:0] DLY_CYCLES = RPM_DLY_CYCLES
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// supply detectors, fuse and pins
	input wire logic I_POR_OK,
	input wire logic I_BROWNOUT_DETECT_OK,
	input wire logic I_OSC_BYPASS,
	input wire logic I_RST_PIN,
	input wire logic I_WAKE_INTERRUPT_ZERO_N,
	input wire logic I_WAKE_INTERRUPT_ONE_N,
	input wire logic I_CLOCK_INPUT_PIN,
	// core side
	input wire logic I_IRQ_PENDING,
	output rpm_pwr_t O_PWR,
	output logic O_CLK_DIV2,
	output logic [15:0] O_RESET_VEC
);

	logic [5:0] sync_in;
	logic [5:0] sync_out;
	logic rst_pin_s, por_s, bod_s, wake0_s, wake1_s, xclk_s;

	assign sync_in = {I_CLOCK_INPUT_PIN, I_WAKE_INTERRUPT_ONE_N, I_WAKE_INTERRUPT_ZERO_N,
		I_BROWNOUT_DETECT_OK, I_POR_OK, I_RST_PIN};

	rpm_sync #(.W(6)) u_sync (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_d(sync_in),
		.o_q(sync_out)
	);

	assign rst_pin_s = sync_out[0];
	assign por_s = sync_out[1];
	assign bod_s = sync_out[2];
	assign wake0_s = sync_out[3];
	assign wake1_s = sync_out[4];
	assign xclk_s = sync_out[5];

	rpm_state_t state_q, state_d;
	logic [15:0] dly_q, dly_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic idle_q, idle_d, pd_q, pd_d, cold_q, cold_d, wds_q, wds_d;
	logic [3:0] wcfg_q, wcfg_d;
	logic wsrc_q, wsrc_d;
	logic [1:0] wprev_q, wprev_d;
	logic xprev_q, xprev_d, xdiv_q, xdiv_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	rpm_pwr_t out_q, out_d;
	logic ext_rst, rst_src, acc, commit, fall0, fall1, wake_rise;

	assign ext_rst = (rcnt_q == RPM_RST_HOLD_CYCLES); // [R1]
	assign rst_src = !por_s || !bod_s || ext_rst; // [R3]
	assign acc = I_PSEL && I_PENABLE && !pready_q;
	assign commit = I_PSEL && I_PENABLE && pready_q;
	// wake only from an enabled, level-sensitive pin
	assign fall0 = wprev_q[0] && !wake0_s && wcfg_q[RPM_WEN_LSB] && wcfg_q[RPM_WLVL_LSB]; // [R16]
	assign fall1 = wprev_q[1] && !wake1_s && wcfg_q[RPM_WEN_LSB+1]
		&& wcfg_q[RPM_WLVL_LSB+1]; // [R16]
	assign wake_rise = wsrc_q ? (!wprev_q[1] && wake1_s) : (!wprev_q[0] && wake0_s);

	always_comb
	begin
		state_d = state_q;
		dly_d = dly_q;
		idle_d = idle_q;
		pd_d = pd_q;
		cold_d = cold_q;
		wds_d = wds_q;
		wcfg_d = wcfg_q;
		wsrc_d = wsrc_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		wprev_d = {wake1_s, wake0_s};
		xprev_d = xclk_s;
		xdiv_d = xdiv_q;
		out_d = '0;
		// only the rising input edge toggles, so input duty cycle is irrelevant
		if (xclk_s && !xprev_q)
			xdiv_d = ~xdiv_q; // [R8]
		// pin must stay high continuously; a glitch restarts the count
		if (!rst_pin_s)
			rcnt_d = 4'h0;
		else if (rcnt_q != RPM_RST_HOLD_CYCLES)
			rcnt_d = rcnt_q + 4'h1; // [R1]
		else
			rcnt_d = rcnt_q;
		// apb: one wait state so read data and pready come from flops
		if (acc)
		begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			case (I_PADDR)
				RPM_POWER_CONTROL_REGISTER_OFS:
				begin
					prdata_d[RPM_IDLE_BIT] = idle_q;
					prdata_d[RPM_PD_BIT] = pd_q;
					prdata_d[RPM_COLD_BIT] = cold_q;
				end
				RPM_CLKCTL_OFS: prdata_d[RPM_WDS_BIT] = wds_q;
				RPM_WAKECFG_OFS: prdata_d[3:0] = wcfg_q;
				RPM_STATUS_OFS:
				begin
					prdata_d[RPM_ST_STATE_LSB +: 3] = state_q;
					prdata_d[RPM_ST_RST_BIT] = out_q.cpu_rst;
					prdata_d[RPM_ST_OSC_BIT] = out_q.osc_en;
					prdata_d[RPM_ST_WSRC_BIT] = wsrc_q;
				end
				default: pslverr_d = 1'b1;
			endcase
		end
		if (commit && I_PWRITE)
		begin
			case (I_PADDR)
				RPM_POWER_CONTROL_REGISTER_OFS:
				begin
					idle_d = I_PWDATA[RPM_IDLE_BIT]; // [R9]
					pd_d = I_PWDATA[RPM_PD_BIT]; // [R13]
					cold_d = I_PWDATA[RPM_COLD_BIT];
				end
				RPM_CLKCTL_OFS: wds_d = I_PWDATA[RPM_WDS_BIT];
				RPM_WAKECFG_OFS: wcfg_d = I_PWDATA[3:0];
				default: ;
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (!por_s)
			cold_d = 1'b1; // [R7]
		case (state_q)
			RPM_ST_RESET:
			begin
				if (dly_q == DLY_CYCLES - 16'h0001)
					state_d = RPM_ST_RUN; // [R4]
				else
					dly_d = dly_q + 16'h0001; // [R4]
			end
			RPM_ST_RUN:
			begin
				// power-down outranks idle if both are requested
				if (pd_q)
					state_d = RPM_ST_PD; // [R13]
				else if (idle_q)
					state_d = RPM_ST_IDLE; // [R9]
			end
			RPM_ST_IDLE:
			begin
				if (I_IRQ_PENDING)
				begin
					state_d = RPM_ST_RUN; // [R12]
					idle_d = 1'b0; // [R21]
					out_d.wake_irq = 1'b1; // [R12]
				end
			end
			RPM_ST_PD:
			begin
				if (fall0 || fall1)
				begin
					wsrc_d = !fall0;
					dly_d = 16'h0000;
					state_d = wds_q ? RPM_ST_WAKE_EXT : RPM_ST_WAKE_TIMED; // [R17] [R19]
				end
			end
			RPM_ST_WAKE_TIMED:
			begin
				if (dly_q == DLY_CYCLES - 16'h0001)
				begin
					state_d = RPM_ST_RUN; // [R17]
					pd_d = 1'b0; // [R21]
					out_d.wake_irq = 1'b1;
				end
				else
					dly_d = dly_q + 16'h0001;
			end
			RPM_ST_WAKE_EXT:
			begin
				// the far end holds the pin low long enough for the oscillator
				if (wake_rise)
				begin
					state_d = RPM_ST_RUN; // [R19] [R20]
					pd_d = 1'b0; // [R21]
					out_d.wake_irq = 1'b1;
				end
			end
			default: state_d = RPM_ST_RESET;
		endcase
		// any source forces reset from any state, power-down included
		if (rst_src)
		begin
			state_d = RPM_ST_RESET; // [R3] [R5] [R14]
			dly_d = 16'h0000;
			idle_d = 1'b0; // [R2] [R21]
			pd_d = 1'b0; // [R21]
			wds_d = 1'b0; // [R2]
			wcfg_d = RPM_WAKECFG_RST; // [R2]
			out_d.wake_irq = 1'b0;
		end
		out_d.cpu_rst = (state_d == RPM_ST_RESET); // [R3]
		out_d.port_weak_pu = (state_d == RPM_ST_RESET); // [R2]
		out_d.osc_en = (state_d != RPM_ST_PD) && !I_OSC_BYPASS
			&& (state_d != RPM_ST_RESET || por_s); // [R6] [R13]
		out_d.cpu_clk_en = (state_d == RPM_ST_RUN); // [R9] [R17]
		out_d.periph_clk_en = (state_d == RPM_ST_RUN) || (state_d == RPM_ST_IDLE); // [R11]
		out_d.port_hold = (state_d == RPM_ST_IDLE); // [R10]
		out_d.comp_en = (state_d == RPM_ST_RUN); // [R11]
		out_d.flash_pwr_en = (state_d != RPM_ST_PD); // [R13]
		out_d.wake_src = wsrc_d;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			state_q <= RPM_ST_RESET;
			dly_q <= 16'h0000;
			rcnt_q <= 4'h0;
			idle_q <= 1'b0;
			pd_q <= 1'b0;
			cold_q <= 1'b0;
			wds_q <= 1'b0;
			wcfg_q <= RPM_WAKECFG_RST;
			wsrc_q <= 1'b0;
			wprev_q <= 2'h3;
			xprev_q <= 1'b0;
			xdiv_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			out_q <= '{cpu_rst: 1'b1, port_weak_pu: 1'b1, flash_pwr_en: 1'b1, default: 1'b0};
		end
		else
		begin
			state_q <= state_d;
			dly_q <= dly_d;
			rcnt_q <= rcnt_d;
			idle_q <= idle_d;
			pd_q <= pd_d;
			cold_q <= cold_d;
			wds_q <= wds_d;
			wcfg_q <= wcfg_d;
			wsrc_q <= wsrc_d;
			wprev_q <= wprev_d;
			xprev_q <= xprev_d;
			xdiv_q <= xdiv_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			out_q <= out_d;
		end
	end

	assign O_PWR = out_q;
	assign O_CLK_DIV2 = xdiv_q;
	assign O_PRDATA = prdata_q;
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_RESET_VEC = RPM_RESET_VECTOR; // [R2]

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	sequence pd_to_ext_s;
		(state_q == RPM_ST_PD) ##1 (state_q == RPM_ST_WAKE_EXT);
	endsequence
	sequence xedge_s;
		xclk_s && !xprev_q;
	endsequence

	por_loss_rst_a: assert property (!por_s |=> O_PWR.cpu_rst && cold_q) // [R5]
		else $error("power-on loss did not reset and flag cold start");
	brownout_rst_a: assert property (!bod_s |=> O_PWR.cpu_rst) // [R3]
		else $error("brown-out did not hold internal reset");
	pin_reset_a: assert property (ext_rst |=> O_PWR.cpu_rst && !idle_q && !pd_q) // [R1]
		else $error("qualified reset pin did not reset the device");
	release_delay_a: assert property ($fell(O_PWR.cpu_rst) // [R4]
		|-> $past(dly_q) == DLY_CYCLES - 16'h0001)
		else $error("reset released before the delay elapsed");
	reset_pullup_a: assert property (O_PWR.cpu_rst // [R2]
		|-> O_PWR.port_weak_pu && !O_PWR.cpu_clk_en)
		else $error("ports not pulled up during reset");
	clk_divide_a: assert property (xedge_s |=> xdiv_q != $past(xdiv_q)) // [R8]
		else $error("divider did not toggle on input edge");
	idle_gate_a: assert property ((state_q == RPM_ST_IDLE) |-> !O_PWR.cpu_clk_en // [R9]
		&& O_PWR.periph_clk_en && O_PWR.port_hold && !O_PWR.comp_en)
		else $error("idle outputs wrong");
	idle_exit_a: assert property ((state_q == RPM_ST_IDLE && I_IRQ_PENDING && !rst_src) // [R12]
		|=> O_PWR.wake_irq && !idle_q && O_PWR.cpu_clk_en)
		else $error("idle did not end on interrupt");
	pd_stop_a: assert property ((state_q == RPM_ST_PD) // [R13]
		|-> !O_PWR.osc_en && !O_PWR.flash_pwr_en)
		else $error("oscillator or flash still on in power-down");
	pd_wake_cfg_a: assert property ((state_q == RPM_ST_PD) && !rst_src && !fall0 && !fall1 // [R16]
		|=> state_q == RPM_ST_PD)
		else $error("power-down left without a qualifying wake");
	timed_wake_a: assert property ((state_q == RPM_ST_WAKE_TIMED) |-> !O_PWR.cpu_clk_en // [R17]
		&& (O_PWR.osc_en || I_OSC_BYPASS))
		else $error("clock not gated during timed wake");
	ext_wake_a: assert property (pd_to_ext_s |-> !O_PWR.cpu_clk_en && pd_q) // [R19]
		else $error("external wake released clock too early");

endmodule : rpm_top

// ### dv/rpm_partner.sv
// Purpose: model of the external reset source and the two wake pins
// Assumes: wake pins have pull-ups, so a released wake pin reads high
// Notes: changes pins only after a rising edge
module rpm_partner (
	// clock
	input wire logic i_clk,
	// pins
	output logic o_rst_pin,
	output logic o_wake_zero_n,
	output logic o_wake_one_n
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		o_rst_pin = 1'b0;
		o_wake_zero_n = 1'b1;
		o_wake_one_n = 1'b1;
	end

	// short pulses are only asked for to show that they are ignored
	task automatic reset_pulse(input int n);
		@(posedge i_clk);
		o_rst_pin <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_rst_pin <= 1'b0;
	endtask : reset_pulse

	// the caller picks a low time past resume and past oscillator start
	task automatic wake(input logic pin, input int n);
		@(posedge i_clk);
		if (pin)
			o_wake_one_n <= 1'b0;
		else
			o_wake_zero_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_wake_zero_n <= 1'b1;
		o_wake_one_n <= 1'b1;
	endtask : wake
endmodule : rpm_partner

// ### dv/reset_and_power_mode_control_tb_top.sv
// Purpose: self-checking bench for the reset and power-mode controller
// Assumes: delay count shortened to 20 cycles, fixed random seed
// Notes: pw mirrors the power struct, bit 9 cpu_rst down to bit 0 wake_src
module reset_and_power_mode_control_tb_top import rpm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] DLY = 16'h0014;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic por = 1'b0;
	logic brownout_detect = 1'b0;
	logic byp = 1'b0;
	logic ckin = 1'b0;
	logic irq = 1'b0;
	logic rst_pin, w0_n, w1_n, ready, slverr, div2, err;
	logic [31:0] prdata, rd;
	logic [15:0] vec;
	rpm_pwr_t pwr_s;
	logic [9:0] pw;
	int fail_count = 0;
	int n_compared = 0;
	int cyc, rises, len;
	assign pw = pwr_s;

	initial
	begin
		forever #50 clk = ~clk;
	end

	rpm_top #(.DLY_CYCLES(DLY)) dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(ready),
		.O_PSLVERR(slverr), .I_POR_OK(por), .I_BROWNOUT_DETECT_OK(brownout_detect),
		.I_OSC_BYPASS(byp), .I_RST_PIN(rst_pin), .I_WAKE_INTERRUPT_ZERO_N(w0_n),
		.I_WAKE_INTERRUPT_ONE_N(w1_n), .I_CLOCK_INPUT_PIN(ckin), .I_IRQ_PENDING(irq),
		.O_PWR(pwr_s), .O_CLK_DIV2(div2), .O_RESET_VEC(vec));

	rpm_partner p (.i_clk(clk), .o_rst_pin(rst_pin), .o_wake_zero_n(w0_n),
		.o_wake_one_n(w1_n));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up;
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic bail;
		chk(32'h0, 32'h1);
		wrap_up();
	endtask : bail

	task automatic wait_pwr(input int b, input logic v, input int lim);
		cyc = 0;
		do
		begin
			@(negedge clk);
			cyc++;
		end
		while (pw[b] !== v && cyc < lim);
		// realign so that the caller drives inputs right after a rising edge
		@(posedge clk);
		if (pw[b] !== v)
			bail();
	endtask : wait_pwr

	// request held until pready is sampled high at a rising edge, released right after it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ready !== 1'b1 && n < 20);
		rd = prdata;
		err = slverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (ready !== 1'b1)
			bail();
	endtask : apb

	initial
	begin
		void'($urandom(25736));
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk(pw[9], 1'b1);
		chk(pw[4], 1'b1);
		chk(vec, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		por <= 1'b1;
		byp <= 1'b1;
		repeat (6) @(posedge clk);
		chk(pw[8], 1'b0);
		byp <= 1'b0;
		repeat (6) @(posedge clk);
		chk(pw[8], 1'b1);
		chk(pw[9], 1'b1);
		brownout_detect <= 1'b1;
		wait_pwr(9, 1'b0, DLY + 10);
		chk(cyc >= DLY, 1'b1);
		apb(1'b0, RPM_STATUS_OFS, 32'h0);
		chk(rd, 32'(RPM_ST_RUN) | (32'h1 << RPM_ST_OSC_BIT));
		apb(1'b0, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		chk(rd[4], 1'b1);
		apb(1'b1, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		rises = 0;
		repeat ($urandom_range(60, 30))
		begin
			repeat ($urandom_range(6, 2)) @(posedge clk);
			ckin <= ~ckin;
			rises += (ckin == 1'b0);
		end
		repeat (6) @(posedge clk);
		chk(div2, rises[0]);
		apb(1'b1, RPM_POWER_CONTROL_REGISTER_OFS, 32'h1);
		wait_pwr(7, 1'b0, 4);
		chk(pw[6:3], 4'hc);
		repeat ($urandom_range(20, 5)) @(posedge clk);
		chk(pw[7], 1'b0);
		apb(1'b0, RPM_STATUS_OFS, 32'h0);
		chk(rd, 32'(RPM_ST_IDLE) | (32'h1 << RPM_ST_OSC_BIT));
		irq <= 1'b1;
		wait_pwr(1, 1'b1, 4);
		chk(pw[7], 1'b1);
		irq <= 1'b0;
		apb(1'b0, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		chk(rd[0], 1'b0);
		apb(1'b1, RPM_WAKECFG_OFS, 32'h5);
		apb(1'b1, RPM_CLKCTL_OFS, 32'h0);
		apb(1'b1, RPM_POWER_CONTROL_REGISTER_OFS, 32'h2);
		wait_pwr(8, 1'b0, 4);
		chk(pw[7:6], 2'b00);
		chk(pw[2], 1'b0);
		fork
			p.wake(1'b0, DLY + 10);
			wait_pwr(7, 1'b1, DLY + 10);
		join
		chk(cyc >= DLY, 1'b1);
		chk(pw[0], 1'b0);
		apb(1'b0, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		chk(rd[1], 1'b0);
		repeat (40) @(posedge clk);
		apb(1'b1, RPM_WAKECFG_OFS, 32'ha);
		apb(1'b0, RPM_WAKECFG_OFS, 32'h0);
		chk(rd, 32'ha);
		apb(1'b1, RPM_CLKCTL_OFS, 32'h4);
		apb(1'b0, RPM_CLKCTL_OFS, 32'h0);
		chk(rd, 32'h1 << RPM_WDS_BIT);
		apb(1'b1, RPM_POWER_CONTROL_REGISTER_OFS, 32'h2);
		wait_pwr(8, 1'b0, 4);
		len = $urandom_range(60, 25);
		fork
			p.wake(1'b1, len);
			begin
				repeat (len) @(negedge clk);
				chk(pw[8:7], 2'b10);
			end
		join
		wait_pwr(7, 1'b1, 6);
		chk(pw[0], 1'b1);
		repeat (40) @(posedge clk);
		apb(1'b1, RPM_WAKECFG_OFS, 32'h1);
		apb(1'b1, RPM_CLKCTL_OFS, 32'h0);
		apb(1'b1, RPM_POWER_CONTROL_REGISTER_OFS, 32'h2);
		wait_pwr(8, 1'b0, 4);
		p.wake(1'b0, DLY + 10);
		chk(pw[8:7], 2'b00);
		p.reset_pulse(6);
		repeat (6) @(posedge clk);
		chk(pw[9], 1'b0);
		fork
			p.reset_pulse(14);
			wait_pwr(9, 1'b1, 20);
		join
		wait_pwr(9, 1'b0, DLY + 20);
		apb(1'b0, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		chk(rd[4:0], 5'h00);
		por <= 1'b0;
		wait_pwr(9, 1'b1, 6);
		por <= 1'b1;
		wait_pwr(9, 1'b0, DLY + 10);
		apb(1'b0, RPM_POWER_CONTROL_REGISTER_OFS, 32'h0);
		chk(rd[4], 1'b1);
		brownout_detect <= 1'b0;
		wait_pwr(9, 1'b1, 6);
		brownout_detect <= 1'b1;
		wait_pwr(9, 1'b0, DLY + 10);
		wrap_up();
	end
endmodule : reset_and_power_mode_control_tb_top
